/* verilog/nmc_pkg.sv */
/*
 * Constants, field layouts and helpers of the configuration bank.
 * Assumes byte-wide nonvolatile storage and a word-wide register port.
 */
package nmc_pkg;
  // ********************
  // Widths
  // ********************
  localparam int unsigned AW = 13;
  localparam int unsigned DW = 32;
  localparam int unsigned NVM_AW = 12;
  localparam int unsigned LD_CNT_W = 4;
  localparam logic [LD_CNT_W-1:0] LD_BYTES = 4'h0_00a;

  // ********************
  // Register indexes
  // ********************
  localparam logic [10:0] IDX_THR_VALID = 11'h05c5;
  localparam logic [10:0] IDX_TEMP = 11'h0648;
  localparam logic [10:0] IDX_TB_GROUP = 11'h06a3;
  localparam logic [10:0] IDX_TB_BIT = 11'h06a4;
  localparam logic [10:0] IDX_ATB = 11'h06a5;
  localparam logic [10:0] IDX_PROFILE = 11'h06b1;
  localparam logic [10:0] IDX_SLOTCNT = 11'h06b3;
  localparam logic [10:0] IDX_IRQ_STATUS = 11'h0700;
  localparam logic [10:0] IDX_IRQ_MASK = 11'h0701;
  localparam logic [10:0] IDX_CFG_STATUS = 11'h0702;

  // ********************
  // Fields and codes
  // ********************
  localparam int unsigned THR_VALID_BIT = 0;
  localparam int unsigned PMS_HI_LSB = 6;
  localparam int unsigned PMS_LO_LSB = 4;
  localparam int unsigned RF_HI_LSB = 2;
  localparam int unsigned RF_LO_LSB = 0;
  localparam logic [7:0] TEMP_CODE1_C = 8'h0072;
  localparam logic [7:0] TEMP_CODE2_C = 8'h007d;
  localparam logic [7:0] TEMP_CODE3_C = 8'h0082;
  localparam logic [7:0] ATB_FIRST = 8'h0078;
  localparam logic [7:0] ATB_LAST = 8'h007b;
  localparam logic [7:0] SLOT_ID_FIRST = 8'h0020;
  localparam logic [7:0] SLOT_ID_LAST = 8'h0022;
  localparam logic [7:0] MODE_ISO = 8'h0000;
  localparam logic [7:0] MODE_PAY = 8'h0001;
  localparam logic [7:0] SLOTS_MIN = 8'h0001;
  localparam logic [7:0] SLOTS_MAX = 8'h0003;

  // ********************
  // Reset values
  // ********************
  localparam logic [7:0] RST_BYTE = 8'h0000;
  localparam logic [15:0] RST_PROFILE = 16'h0000;
  localparam logic [23:0] RST_SLOTCNT = 24'h01_00ff;

  // ********************
  // Events and load stream
  // ********************
  localparam int unsigned EV_PMS_HI = 0;
  localparam int unsigned EV_PMS_LO = 1;
  localparam int unsigned EV_RF_HI = 2;
  localparam int unsigned EV_RF_LO = 3;
  localparam int unsigned EV_RESERVED = 4;
  localparam int unsigned EV_LOADED = 5;
  localparam int unsigned EV_W = 6;
  localparam logic [LD_CNT_W-1:0] LD_THR = 4'h0_000;
  localparam logic [LD_CNT_W-1:0] LD_TEMP = 4'h0_001;
  localparam logic [LD_CNT_W-1:0] LD_TBG = 4'h0_002;
  localparam logic [LD_CNT_W-1:0] LD_TBB = 4'h0_003;
  localparam logic [LD_CNT_W-1:0] LD_ATB = 4'h0_004;
  localparam logic [LD_CNT_W-1:0] LD_PROF_HI = 4'h0_005;
  localparam logic [LD_CNT_W-1:0] LD_PROF_LO = 4'h0_006;
  localparam logic [LD_CNT_W-1:0] LD_CNT_B2 = 4'h0_007;
  localparam logic [LD_CNT_W-1:0] LD_CNT_B1 = 4'h0_008;
  localparam logic [LD_CNT_W-1:0] LD_CNT_B0 = 4'h0_009;

  // Storage byte address of each load step
  function automatic logic [NVM_AW-1:0] nvm_byte_addr(
    input logic [LD_CNT_W-1:0] k);
    case (k)
      4'h0_000: nvm_byte_addr = 12'h05c5;
      4'h0_001: nvm_byte_addr = 12'h0648;
      4'h0_002: nvm_byte_addr = 12'h06a3;
      4'h0_003: nvm_byte_addr = 12'h06a4;
      4'h0_004: nvm_byte_addr = 12'h06a5;
      4'h0_005: nvm_byte_addr = 12'h06b1;
      4'h0_006: nvm_byte_addr = 12'h06b2;
      4'h0_007: nvm_byte_addr = 12'h06b3;
      4'h0_008: nvm_byte_addr = 12'h06b4;
      default: nvm_byte_addr = 12'h06b5;
    endcase
  endfunction : nvm_byte_addr

  // Word address match
  function automatic logic reg_hit(input logic [AW-1:0] a,
    input logic [10:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction : reg_hit
endpackage : nmc_pkg

/* verilog/nmc_load_if.sv */
/*
 * Load stream from the storage loader into the register bank.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface nmc_load_if;
  import nmc_pkg::*;
  logic wr;
  logic [LD_CNT_W-1:0] sel;
  logic [7:0] data;
  logic done;
  modport loader(output wr, output sel, output data, output done);
  modport bank(input wr, input sel, input data, input done);
endinterface : nmc_load_if

/* verilog/nmc_loader.sv */
/*
 * Reads every parameter byte from nonvolatile storage after reset.
 * Assumes storage answers each read with a one-cycle acknowledge.
 */
`timescale 1ns/10ps
module nmc_loader
  import nmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Storage read port
  output logic nvm_rd,
  output logic [NVM_AW-1:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic [7:0] nvm_data,
  // Load stream
  nmc_load_if.loader ld
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_REQ = 4'b0010,
    S_WAIT = 4'b0100,
    S_DONE = 4'b1000
  } nmc_ld_state_e;

  nmc_ld_state_e state_q;
  logic [LD_CNT_W-1:0] cnt_q;
  logic [NVM_AW-1:0] addr_q;

  assign nvm_rd = (state_q == S_REQ);
  assign nvm_addr = addr_q;

  // ********************
  // Sequencer
  // ********************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      ld.wr <= 1'b0;
      ld.sel <= '0;
      ld.data <= 8'h0000;
      ld.done <= 1'b0;
    end else if (ce) begin
      ld.wr <= 1'b0;
      case (state_q)
        S_IDLE: begin
          addr_q <= nvm_byte_addr(cnt_q);
          state_q <= S_REQ;
        end
        S_REQ: begin
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (nvm_ack) begin
            ld.wr <= 1'b1;
            ld.sel <= cnt_q;
            ld.data <= nvm_data;
            if (cnt_q == LD_BYTES - 4'h0_001) begin
              state_q <= S_DONE;
            end else begin
              cnt_q <= cnt_q + 4'h0_001;
              addr_q <= nvm_byte_addr(cnt_q + 4'h0_001);
              state_q <= S_REQ;
            end
          end
        end
        S_DONE: begin
          ld.done <= 1'b1;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule : nmc_loader

/* verilog/nmc_bank.sv */
/*
 * Configuration parameter bank: storage load, register port, decoded
 * controls for calibration, temperature warnings, test buses and the
 * contact slots, and a sticky interrupt status.
 * Assumes synchronous inputs, one clock and a storage read port.
 */
`timescale 1ns/10ps
// What this block does
// - A set threshold-valid bit makes the device use stored detect thresholds and skip their calibration.
// - Calibration runs again only after the bit is cleared and a power-on reset follows, never on the clear alone.
// - Power sensor high limit is bits 7:6 and low limit bits 5:4; code 0 is off, 1..3 mean 114, 125, 130 C.
// - RF front-end high limit is bits 3:2 and low limit bits 1:0, with the same codes.
// - An 8-bit group select picks which digital signal group goes to the test bus; undefined codes are reserved.
// - An 8-bit bit select picks which bit of that group is observed; undefined codes are reserved.
// - The analog select takes 0x78..0x7B for patchbox 0..3; every other code is reserved.
// - The profile upper byte names the slot: 0x20, 0x21, 0x22 for slots 1, 2, 3; others are reserved.
// - The profile lower byte picks the mode: 0x00 plain contact, 0x01 payment terminal; others reserved.
// - Slot count byte 15:8 enables slots cumulatively: 1, 2 or 3 slots; codes 0x04 and up are reserved.
module nmc_bank
  import nmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  // Storage read port
  output logic nvm_rd,
  output logic [NVM_AW-1:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic [7:0] nvm_data,
  // Interrupt
  output logic irq,
  // Calibration control
  output logic cal_skip,
  output logic cal_start,
  output logic cfg_ready,
  // Temperature sensors in degrees Celsius
  input wire logic [7:0] pms_temp,
  input wire logic [7:0] rf_temp,
  // Test bus selection
  output logic [7:0] dtb_group,
  output logic [7:0] dtb_bit,
  output logic [3:0] atb_patchbox_en,
  // Contact slots
  output logic [2:0] slot_en,
  output logic [2:0] slot_payment_mode
);
  // ********************
  // Declarations
  // ********************
  nmc_load_if ld ();

  logic [7:0] thr_valid_q;
  logic [7:0] temp_q;
  logic [7:0] tbg_q;
  logic [7:0] tbb_q;
  logic [7:0] atb_q;
  logic [15:0] prof_q;
  logic [23:0] cnt_q;
  logic [2:0] slot_pay_q;
  logic [EV_W-1:0] st_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rd_val;
  logic done_q;
  logic cal_skip_q;
  logic cal_start_q;
  logic bus_wr;
  logic ld_thr;
  logic ld_temp;
  logic ld_tbg;
  logic ld_tbb;
  logic ld_atb;
  logic ld_prof_hi;
  logic ld_prof_lo;
  logic ld_cnt2;
  logic ld_cnt1;
  logic ld_cnt0;
  logic atb_upd;
  logic prof_upd;
  logic cnt_upd;
  logic [7:0] atb_new;
  logic [15:0] prof_new;
  logic [7:0] cnt_new;
  logic prof_ok;
  logic [1:0] slot_idx;
  logic load_fin;

  // ********************
  // Helpers
  // ********************
  // Limit of a two-bit temperature code
  function automatic logic [7:0] temp_limit(input logic [1:0] code);
    case (code)
      2'b01: temp_limit = TEMP_CODE1_C;
      2'b10: temp_limit = TEMP_CODE2_C;
      default: temp_limit = TEMP_CODE3_C;
    endcase
  endfunction : temp_limit

  // Trip of an enabled limit
  function automatic logic temp_trip(input logic [1:0] code,
    input logic [7:0] t);
    temp_trip = (code != 2'b00) && (t >= temp_limit(code));
  endfunction : temp_trip

  // Analog select code in the patchbox range
  function automatic logic atb_ok(input logic [7:0] v);
    atb_ok = (v >= ATB_FIRST) && (v <= ATB_LAST);
  endfunction : atb_ok

  // Slot count code in the defined range
  function automatic logic cnt_ok(input logic [7:0] v);
    cnt_ok = (v >= SLOTS_MIN) && (v <= SLOTS_MAX);
  endfunction : cnt_ok

  // ********************
  // Storage loader
  // ********************
  nmc_loader u_loader (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr),
    .nvm_ack(nvm_ack),
    .nvm_data(nvm_data),
    .ld(ld.loader)
  );

  // ********************
  // Write decode
  // ********************
  assign bus_wr = reg_wr && ld.done;
  assign ld_thr = ld.wr && (ld.sel == LD_THR);
  assign ld_temp = ld.wr && (ld.sel == LD_TEMP);
  assign ld_tbg = ld.wr && (ld.sel == LD_TBG);
  assign ld_tbb = ld.wr && (ld.sel == LD_TBB);
  assign ld_atb = ld.wr && (ld.sel == LD_ATB);
  assign ld_prof_hi = ld.wr && (ld.sel == LD_PROF_HI);
  assign ld_prof_lo = ld.wr && (ld.sel == LD_PROF_LO);
  assign ld_cnt2 = ld.wr && (ld.sel == LD_CNT_B2);
  assign ld_cnt1 = ld.wr && (ld.sel == LD_CNT_B1);
  assign ld_cnt0 = ld.wr && (ld.sel == LD_CNT_B0);

  assign atb_upd = ld_atb || (bus_wr && reg_hit(reg_addr, IDX_ATB));
  assign atb_new = ld_atb ? ld.data : reg_wdata[7:0];
  assign prof_upd = ld_prof_lo ||
                    (bus_wr && reg_hit(reg_addr, IDX_PROFILE));
  assign prof_new = ld_prof_lo ? {prof_q[15:8], ld.data} :
                    reg_wdata[15:0];
  assign cnt_upd = ld_cnt1 || (bus_wr && reg_hit(reg_addr, IDX_SLOTCNT));
  assign cnt_new = ld_cnt1 ? ld.data : reg_wdata[15:8];
  assign prof_ok = (prof_new[15:8] >= SLOT_ID_FIRST) &&
                   (prof_new[15:8] <= SLOT_ID_LAST) &&
                   ((prof_new[7:0] == MODE_ISO) ||
                    (prof_new[7:0] == MODE_PAY));
  assign slot_idx = 2'(prof_new[15:8] - SLOT_ID_FIRST);

  // ********************
  // Parameter registers
  // ********************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thr_valid_q <= RST_BYTE;
    end else if (ce) begin
      if (ld_thr) begin
        thr_valid_q <= {7'h0_000, ld.data[THR_VALID_BIT]};
      end else if (bus_wr && reg_hit(reg_addr, IDX_THR_VALID)) begin
        thr_valid_q <= {7'h0_000, reg_wdata[THR_VALID_BIT]};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temp_q <= RST_BYTE;
    end else if (ce) begin
      if (ld_temp) begin
        temp_q <= ld.data;
      end else if (bus_wr && reg_hit(reg_addr, IDX_TEMP)) begin
        temp_q <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tbg_q <= RST_BYTE;
      tbb_q <= RST_BYTE;
    end else if (ce) begin
      if (ld_tbg) begin
        tbg_q <= ld.data;
      end else if (bus_wr && reg_hit(reg_addr, IDX_TB_GROUP)) begin
        tbg_q <= reg_wdata[7:0];
      end
      if (ld_tbb) begin
        tbb_q <= ld.data;
      end else if (bus_wr && reg_hit(reg_addr, IDX_TB_BIT)) begin
        tbb_q <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      atb_q <= RST_BYTE;
    end else if (ce && atb_upd) begin
      atb_q <= atb_new;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prof_q <= RST_PROFILE;
    end else if (ce) begin
      if (ld_prof_hi) begin
        prof_q[15:8] <= ld.data;
      end else if (prof_upd) begin
        prof_q <= prof_new;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= RST_SLOTCNT;
    end else if (ce) begin
      if (ld_cnt2) begin
        cnt_q[23:16] <= ld.data;
      end else if (ld_cnt1) begin
        cnt_q[15:8] <= ld.data;
      end else if (ld_cnt0) begin
        cnt_q[7:0] <= ld.data;
      end else if (cnt_upd) begin
        cnt_q <= reg_wdata[23:0];
      end
    end
  end

  // Per-slot mode, only defined slot and mode codes take effect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot_pay_q <= 3'h0_000;
    end else if (ce && prof_upd && prof_ok) begin
      slot_pay_q[slot_idx] <= prof_new[0];
    end
  end

  // ********************
  // Calibration control
  // ********************
  assign load_fin = ld.done && !done_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      cal_skip_q <= 1'b0;
      cal_start_q <= 1'b0;
    end else if (ce) begin
      done_q <= ld.done;
      cal_start_q <= 1'b0;
      // Decided once per reset from the loaded flag
      if (load_fin) begin
        cal_skip_q <= thr_valid_q[THR_VALID_BIT];
        cal_start_q <= !thr_valid_q[THR_VALID_BIT];
      end
    end
  end

  // ********************
  // Events and interrupt
  // ********************
  always_comb begin
    ev = '0;
    if (done_q) begin
      ev[EV_PMS_HI] = temp_trip(temp_q[PMS_HI_LSB +: 2], pms_temp);
      ev[EV_PMS_LO] = temp_trip(temp_q[PMS_LO_LSB +: 2], pms_temp);
      ev[EV_RF_HI] = temp_trip(temp_q[RF_HI_LSB +: 2], rf_temp);
      ev[EV_RF_LO] = temp_trip(temp_q[RF_LO_LSB +: 2], rf_temp);
    end
    ev[EV_RESERVED] = (atb_upd && !atb_ok(atb_new)) ||
                      (prof_upd && !prof_ok) ||
                      (cnt_upd && !cnt_ok(cnt_new));
    ev[EV_LOADED] = load_fin;
  end

  assign clr = (bus_wr && reg_hit(reg_addr, IDX_IRQ_STATUS)) ?
               reg_wdata[EV_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= (st_q & ~clr) | ev;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= '0;
    end else if (ce && bus_wr && reg_hit(reg_addr, IDX_IRQ_MASK)) begin
      mask_q <= reg_wdata[EV_W-1:0];
    end
  end

  assign irq = |(st_q & mask_q);

  // ********************
  // Read port
  // ********************
  always_comb begin
    rd_val = '0;
    if (reg_hit(reg_addr, IDX_THR_VALID)) begin
      rd_val[7:0] = thr_valid_q;
    end else if (reg_hit(reg_addr, IDX_TEMP)) begin
      rd_val[7:0] = temp_q;
    end else if (reg_hit(reg_addr, IDX_TB_GROUP)) begin
      rd_val[7:0] = tbg_q;
    end else if (reg_hit(reg_addr, IDX_TB_BIT)) begin
      rd_val[7:0] = tbb_q;
    end else if (reg_hit(reg_addr, IDX_ATB)) begin
      rd_val[7:0] = atb_q;
    end else if (reg_hit(reg_addr, IDX_PROFILE)) begin
      rd_val[15:0] = prof_q;
    end else if (reg_hit(reg_addr, IDX_SLOTCNT)) begin
      rd_val[23:0] = cnt_q;
    end else if (reg_hit(reg_addr, IDX_IRQ_STATUS)) begin
      rd_val[EV_W-1:0] = st_q;
    end else if (reg_hit(reg_addr, IDX_IRQ_MASK)) begin
      rd_val[EV_W-1:0] = mask_q;
    end else if (reg_hit(reg_addr, IDX_CFG_STATUS)) begin
      rd_val[2:0] = {slot_pay_q != 3'h0_000, cal_skip_q, done_q};
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= reg_rd ? rd_val : '0;
    end
  end

  assign reg_rdata = rdata_q;

  // ********************
  // Controls out
  // ********************
  assign cal_skip = cal_skip_q;
  assign cal_start = cal_start_q;
  assign cfg_ready = done_q;
  assign dtb_group = done_q ? tbg_q : 8'h0000;
  assign dtb_bit = done_q ? tbb_q : 8'h0000;

  // One patchbox per defined code, none for reserved codes
  always_comb begin
    atb_patchbox_en = 4'h0_000;
    if (done_q && atb_ok(atb_q)) begin
      atb_patchbox_en[2'(atb_q - ATB_FIRST)] = 1'b1;
    end
  end

  // Cumulative enables from the slot count byte
  always_comb begin
    slot_en = 3'h0_000;
    if (done_q) begin
      case (cnt_q[15:8])
        8'h0001: slot_en = 3'h0_001;
        8'h0002: slot_en = 3'h0_003;
        8'h0003: slot_en = 3'h0_007;
        default: slot_en = 3'h0_000;
      endcase
    end
  end

  assign slot_payment_mode = done_q ? slot_pay_q : 3'h0_000;
endmodule : nmc_bank

/* verif/nmc_bank_checker.sv */
/*
 * Port checker of the configuration bank.
 * Assumes one clock and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module nmc_bank_checker
  import nmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Observed outputs
  input wire logic nvm_rd,
  input wire logic cal_skip,
  input wire logic cal_start,
  input wire logic cfg_ready,
  input wire logic [7:0] dtb_group,
  input wire logic [7:0] dtb_bit,
  input wire logic [3:0] atb_patchbox_en,
  input wire logic [2:0] slot_en,
  input wire logic [2:0] slot_payment_mode
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SKIP_NO_START: assert property (cal_skip |-> !cal_start)
    else $error("calibration started while skipped");
  AST_START_PULSE: assert property (cal_start |=> !cal_start)
    else $error("calibration start longer than one cycle");
  AST_SKIP_STEADY: assert property
    (cfg_ready && $past(cfg_ready) |-> $stable(cal_skip))
    else $error("skip changed without reset");
  AST_ATB_ONEHOT: assert property ($onehot0(atb_patchbox_en))
    else $error("more than one patchbox");
  AST_SLOT_CUMUL: assert property (slot_en inside {0, 1, 3, 7})
    else $error("slot enables not cumulative");
  AST_IDLE_BEFORE_READY: assert property (!cfg_ready |->
    {dtb_group, dtb_bit, atb_patchbox_en, slot_en, slot_payment_mode} == 0)
    else $error("control applied before load");
  AST_NO_FETCH_AFTER_READY: assert property (nvm_rd |-> !cfg_ready)
    else $error("storage read after ready");
  AST_READY_HOLDS: assert property (cfg_ready |=> cfg_ready)
    else $error("ready dropped");
endmodule : nmc_bank_checker

bind nmc_bank nmc_bank_checker i_chk(.clk, .nrst, .nvm_rd, .cal_skip,
  .cal_start, .cfg_ready, .dtb_group, .dtb_bit, .atb_patchbox_en,
  .slot_en, .slot_payment_mode);

/* verif/tb.sv */
/*
 * Self-checking bench of the configuration bank.
 * Assumes the checker is bound; the bench stands in for storage.
 */
`timescale 1ns/10ps
module tb;
  import nmc_pkg::*;
  logic clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, nvm_ack = 0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0, reg_rdata;
  logic [NVM_AW-1:0] nvm_addr;
  logic [7:0] nvm_data = 0, pms_temp = 0, rf_temp = 0, dtb_group, dtb_bit;
  logic nvm_rd, irq, cal_skip, cal_start, cfg_ready;
  logic [3:0] atb_patchbox_en;
  logic [2:0] slot_en, slot_payment_mode;
  logic [7:0] nv [4096];
  logic [7:0] lim [1:3] = '{8'h72, 8'h7d, 8'h82};
  int fail_count = 0, checked = 0, starts = 0, cyc = 0;

  always #10 clk = ~clk;
  nmc_bank i_dut(.clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .nvm_rd, .nvm_addr, .nvm_ack, .nvm_data, .irq, .cal_skip,
    .cal_start, .cfg_ready, .pms_temp, .rf_temp, .dtb_group, .dtb_bit,
    .atb_patchbox_en, .slot_en, .slot_payment_mode);

  // Storage answers one cycle after each request, else garbage
  always @(posedge clk) begin
    nvm_ack <= nvm_rd;
    nvm_data <= nvm_rd ? nv[nvm_addr] : ~nvm_data;
    if (cal_start === 1'b1) starts++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // ********
  // Shared tasks
  // ********
  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [10:0] i, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr <= {i, 2'b00};
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask : wr
  task rchk(input logic [10:0] i, input logic [DW-1:0] e);
    @(posedge clk);
    reg_addr <= {i, 2'b00};
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rchk
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task temps(input logic [7:0] p, input logic [7:0] r);
    @(posedge clk);
    pms_temp <= p;
    rf_temp <= r;
  endtask : temps
  task boot(input logic [7:0] valid);
    int n;
    nv[12'h5c5] = valid;
    nv[12'h648] = 8'h55;
    nv[12'h6a3] = 8'h12;
    nv[12'h6a4] = 8'h05;
    nv[12'h6a5] = 8'h79;
    nv[12'h6b1] = 8'h21;
    nv[12'h6b2] = 8'h01;
    nv[12'h6b3] = 8'h01;
    nv[12'h6b4] = 8'h02;
    nv[12'h6b5] = 8'h00;
    nrst <= 0;
    repeat (16) @(posedge clk);
    starts = 0;
    chk({cfg_ready, cal_skip, slot_en, atb_patchbox_en}, 0);
    nrst <= 1;
    wr(IDX_IRQ_MASK, 32'h0000_003f);
    for (n = 0; n < 200 && cfg_ready !== 1'b1; n++) @(posedge clk);
    chk(cfg_ready, 1);
    repeat (3) @(posedge clk);
  endtask : boot

  // ********
  // Scenarios
  // ********
  task t_load;
    chk(cal_skip, 1);
    chk(starts, 0);
    chk(irq, 0);
    chk(dtb_group, 8'h12);
    chk(dtb_bit, 8'h05);
    chk(atb_patchbox_en, 4'b0010);
    chk(slot_en, 3'b011);
    chk(slot_payment_mode, 3'b010);
    rchk(IDX_TEMP, 32'h0000_0055);
    rchk(IDX_PROFILE, 32'h0000_2101);
    rchk(IDX_SLOTCNT, 32'h0001_0200);
    rchk(IDX_IRQ_STATUS, 32'h0000_0020);
    rchk(11'h0100, 0);
    $display("test load done");
  endtask : t_load
  task t_codes;
    int c;
    wr(IDX_TB_GROUP, 32'h0000_00a5);
    wr(IDX_TB_BIT, 32'h0000_003c);
    settle;
    chk(dtb_group, 8'ha5);
    chk(dtb_bit, 8'h3c);
    ce <= 0;
    wr(IDX_TB_GROUP, 32'h0000_005a);
    ce <= 1;
    settle;
    chk(dtb_group, 8'ha5);
    for (c = 8'h77; c <= 8'h7c; c++) begin
      wr(IDX_ATB, c);
      settle;
      chk(atb_patchbox_en, (c > 8'h77 && c < 8'h7c) ? 1 << (c - 8'h78) : 0);
    end
    for (c = 1; c <= 4; c++) begin
      wr(IDX_SLOTCNT, {8'h01, c[7:0], 8'hff});
      settle;
      chk(slot_en, c < 4 ? 7 >> (3 - c) : 0);
    end
    for (c = 0; c < 3; c++) wr(IDX_PROFILE, {8'h20 + c[7:0], 7'h0, c != 1});
    wr(IDX_IRQ_STATUS, 32'h0000_003f);
    wr(IDX_PROFILE, 32'h0000_2300);
    wr(IDX_PROFILE, 32'h0000_2002);
    settle;
    chk(slot_payment_mode, 3'b101);
    rchk(IDX_IRQ_STATUS, 32'h0000_0010);
    $display("test codes done");
  endtask : t_codes
  task t_temp;
    int k;
    for (k = 1; k <= 3; k++) begin
      wr(IDX_TEMP, {24'h0, {4{k[1:0]}}});
      temps(lim[k] - 1, lim[k] - 1);
      wr(IDX_IRQ_STATUS, 32'h0000_003f);
      settle;
      rchk(IDX_IRQ_STATUS, 0);
      temps(lim[k], lim[k]);
      settle;
      rchk(IDX_IRQ_STATUS, 32'h0000_000f);
    end
    wr(IDX_IRQ_MASK, 32'h0000_0008);
    settle;
    chk(irq, 1);
    wr(IDX_IRQ_STATUS, 32'h0000_000f);
    rchk(IDX_IRQ_STATUS, 32'h0000_000f);
    wr(IDX_TEMP, 0);
    temps(8'hff, 8'hff);
    wr(IDX_IRQ_STATUS, 32'h0000_003f);
    settle;
    chk(irq, 0);
    rchk(IDX_IRQ_STATUS, 0);
    $display("test temperature done");
  endtask : t_temp
  task t_recal;
    wr(IDX_THR_VALID, 0);
    settle;
    chk(cal_skip, 1);
    chk(starts, 0);
    rchk(IDX_CFG_STATUS, 32'h0000_0007);
    boot(8'h00);
    chk(cal_skip, 0);
    chk(starts, 1);
    $display("test recalibration done");
  endtask : t_recal

  task summarize;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    boot(8'h01);
    t_load;
    t_codes;
    t_temp;
    t_recal;
    summarize();
  end
endmodule : tb
